//--- rsc_seq.sv
// Repeated start and stop sequencer with bus collision detection
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module rsc_seq
   import rsc_pkg::*;
#(
   parameter int RELOAD_W = rsc_pkg::RSC_RELOAD_W
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Sequence control
   input wire logic [RELOAD_W-1:0] baud_reload_value,
   input wire logic rstart_req,
   input wire logic stop_req,
   input wire logic flag_clear,
   output logic rstart_en,
   output logic stop_en,
   output logic bus_collision_flag,
   output logic seq_done,
   // Open-drain bus lines
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe
);
   import rsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Line synchronisers
   logic [1:0] sda_sync;
   logic [1:0] scl_sync;
   logic scl_prev;
   logic sda;
   logic scl;
   logic scl_rise;
   logic scl_fall;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sda_sync <= 2'h3;
         scl_sync <= 2'h3;
         scl_prev <= 1'b1;
      end else begin
         sda_sync <= {sda_sync[0], sda_i};
         scl_sync <= {scl_sync[0], scl_i};
         scl_prev <= scl_sync[1];
      end
   end

   assign sda = sda_sync[1];
   assign scl = scl_sync[1];
   assign scl_rise = scl && !scl_prev;
   assign scl_fall = !scl && scl_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   rsc_state_t state;
   rsc_state_t next_state;
   logic [RELOAD_W-1:0] baud_rate_counter;
   logic cnt_zero;
   logic collide;
   logic load;
   logic sda_drive_low;
   logic scl_drive_low;

   assign cnt_zero = (baud_rate_counter == RELOAD_W'(RSC_COUNT_ZERO));

   always_comb begin
      next_state = state;
      collide = 1'b0;
      load = 1'b0;
      case (state)
         RSC_IDLE: begin
            if (rstart_req) begin
               next_state = RSC_RS_SDA_REL;
            end else if (stop_req) begin
               next_state = RSC_SP_SDA_LOW;
            end
         end
         RSC_RS_SDA_REL: begin
            if (sda) begin
               load = 1'b1;
               next_state = RSC_RS_CNT1;
            end
         end
         RSC_RS_CNT1: begin
            if (cnt_zero) begin
               next_state = RSC_RS_SCL_REL;
            end
         end
         RSC_RS_SCL_REL: begin
            if (scl) begin
               if (!sda || !scl_rise) begin
                  collide = !sda;
                  next_state = sda ? RSC_RS_CNT2 : RSC_IDLE;
               end else begin
                  next_state = RSC_RS_CNT2;
               end
               load = sda;
            end
         end
         RSC_RS_CNT2: begin
            if (scl_fall && sda) begin
               collide = 1'b1;
               next_state = RSC_IDLE;
            end else if (cnt_zero) begin
               if (scl && sda) begin
                  load = 1'b1;
                  next_state = RSC_RS_CNT3;
               end else if (!scl) begin
                  collide = 1'b1;
                  next_state = RSC_IDLE;
               end else begin
                  load = 1'b1;
                  next_state = RSC_RS_CNT3;
               end
            end
         end
         RSC_RS_CNT3: begin
            if (cnt_zero) begin
               next_state = RSC_IDLE;
            end
         end
         RSC_SP_SDA_LOW: begin
            if (!sda) begin
               next_state = RSC_SP_SCL_REL;
            end
         end
         RSC_SP_SCL_REL: begin
            if (scl) begin
               load = 1'b1;
               next_state = RSC_SP_CNT1;
            end
         end
         RSC_SP_CNT1: begin
            if (!scl) begin
               collide = 1'b1;
               next_state = RSC_IDLE;
            end else if (cnt_zero) begin
               load = 1'b1;
               next_state = RSC_SP_CNT2;
            end
         end
         RSC_SP_CNT2: begin
            if (cnt_zero) begin
               collide = !sda;
               next_state = RSC_IDLE;
            end
         end
         default: begin
            next_state = RSC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state <= RSC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Counter runs only in counting states, frozen while waiting on SCL
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         baud_rate_counter <= RELOAD_W'(RSC_RELOAD_RST);
      end else if (load) begin
         baud_rate_counter <= baud_reload_value;
      end else if (!cnt_zero && (state == RSC_RS_CNT1 || state == RSC_RS_CNT2 || state == RSC_RS_CNT3 ||
                                 state == RSC_SP_CNT1 || state == RSC_SP_CNT2)) begin
         baud_rate_counter <= baud_rate_counter - RELOAD_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         bus_collision_flag <= 1'b0;
      end else if (collide) begin
         bus_collision_flag <= 1'b1;
      end else if (flag_clear) begin
         bus_collision_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         seq_done <= 1'b0;
      end else begin
         seq_done <= (next_state == RSC_IDLE) && (state != RSC_IDLE) && !collide;
      end
   end

   assign rstart_en = (state == RSC_RS_SDA_REL) || (state == RSC_RS_CNT1) || (state == RSC_RS_SCL_REL) ||
                      (state == RSC_RS_CNT2) || (state == RSC_RS_CNT3);
   assign stop_en = (state == RSC_SP_SDA_LOW) || (state == RSC_SP_SCL_REL) ||
                    (state == RSC_SP_CNT1) || (state == RSC_SP_CNT2);

   ////////////////////////////////////////////////////////////////////////////
   // Line drivers: pull low or release only
   always_comb begin
      sda_drive_low = 1'b0;
      scl_drive_low = 1'b0;
      case (state)
         RSC_RS_SDA_REL: scl_drive_low = 1'b1;
         RSC_RS_CNT1: scl_drive_low = 1'b1;
         RSC_RS_CNT3: sda_drive_low = 1'b1;
         RSC_SP_SDA_LOW: begin
            sda_drive_low = 1'b1;
            scl_drive_low = 1'b1;
         end
         RSC_SP_SCL_REL: sda_drive_low = 1'b1;
         RSC_SP_CNT1: sda_drive_low = 1'b1;
         default: begin
            sda_drive_low = 1'b0;
            scl_drive_low = 1'b0;
         end
      endcase
   end

   logic scl_hold_low;
   logic rs_hold;

   // Repeated start final count end forces SCL low until a new sequence
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         scl_hold_low <= 1'b0;
      end else if (state == RSC_RS_CNT3 && cnt_zero) begin
         scl_hold_low <= 1'b1;
      end else if (collide || state == RSC_SP_SCL_REL || state == RSC_RS_SCL_REL) begin
         scl_hold_low <= 1'b0;
      end
   end

   // Both lines stay pulled from the end of a repeated start until the next sequence takes over,
   // so SDA never rises while SCL is high, which would put a stop on the bus
   assign rs_hold = (state == RSC_RS_CNT3 && cnt_zero) || (scl_hold_low && state == RSC_IDLE);

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sda_oe <= 1'b0;
         scl_oe <= 1'b0;
      end else begin
         sda_oe <= sda_drive_low || rs_hold;
         scl_oe <= scl_drive_low || rs_hold;
      end
   end

   assign sda_o = 1'b0;
   assign scl_o = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_coll_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
      collide |=> bus_collision_flag) else $error("collision did not set flag");
   a_coll_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      collide |=> state == RSC_IDLE) else $error("collision did not abort");
   a_coll_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
      collide |=> ##1 (!sda_oe && !scl_oe)) else $error("lines not released after collision");
   a_rs_sda_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state == RSC_RS_SCL_REL && scl && !sda) |-> collide) else $error("sda low at scl high missed");
   a_rs_scl_fall: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state == RSC_RS_CNT2 && scl_fall && sda) |-> collide) else $error("scl fall missed");
   a_rs_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state == RSC_RS_SDA_REL && sda) |=> baud_rate_counter == $past(baud_reload_value)) else $error("no load");
   a_scl_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state == RSC_SP_SCL_REL && !scl) |=> $stable(baud_rate_counter)) else $error("count ran on low scl");
   a_sp_scl_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state == RSC_SP_CNT1 && !scl) |-> collide) else $error("stop scl low missed");
   a_sp_sda_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state == RSC_SP_CNT2 && cnt_zero && !sda) |-> collide) else $error("stop sda low missed");
   a_rs_final_scl: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state == RSC_RS_CNT3 && cnt_zero) |=> scl_oe) else $error("scl not driven low");
   a_sp_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state == RSC_SP_SDA_LOW) |=> sda_oe) else $error("stop sda not low");

   // Lines held after a repeated start, and the second count ending with SCL low
   a_rs_hold_lines: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state == RSC_IDLE && scl_hold_low) |=> (sda_oe && scl_oe)) else $error("lines not held after repeated start");
   a_rs_cnt2_scl: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (state == RSC_RS_CNT2 && cnt_zero && !scl) |-> collide) else $error("scl low at second count end missed");
endmodule // rsc_seq

//--- rsc_pkg.sv
// Constants and types for the repeated start / stop sequencer with collision detection
package rsc_pkg;
   localparam int RSC_RELOAD_W = 7;
   localparam logic [6:0] RSC_RELOAD_RST = 7'h00;
   localparam logic [6:0] RSC_COUNT_ZERO = 7'h00;
   localparam int RSC_SYNC_STAGES = 2;

   typedef enum logic [3:0] {
      RSC_IDLE = 4'h0,
      RSC_RS_SDA_REL = 4'h1,
      RSC_RS_CNT1 = 4'h3,
      RSC_RS_SCL_REL = 4'h2,
      RSC_RS_CNT2 = 4'h6,
      RSC_RS_CNT3 = 4'h7,
      RSC_SP_SDA_LOW = 4'h5,
      RSC_SP_SCL_REL = 4'h4,
      RSC_SP_CNT1 = 4'hC,
      RSC_SP_CNT2 = 4'hD
   } rsc_state_t;
endpackage

//--- rsc_bus_peer.sv
// Far-side party on the two open-drain lines: other masters and slaves
`timescale 1ns/100ps
module rsc_bus_peer (
   // Device pull enables
   input wire logic sda_oe,
   input wire logic scl_oe,
   // Far-side pulls
   input wire logic sda_pull,
   input wire logic scl_pull,
   // Resolved line levels
   output logic sda,
   output logic scl
);
   // Pull-ups hold a line high unless some party pulls it low
   assign sda = !(sda_oe || sda_pull);
   assign scl = !(scl_oe || scl_pull);
endmodule // rsc_bus_peer

//--- testbench.sv
// Self-checking bench for the repeated start / stop sequencer
`timescale 1ns/100ps
module testbench;
   import rsc_pkg::*;
   logic sys_clk, rst_b, rstart_req, stop_req, flag_clear, sda_pull, scl_pull;
   logic [6:0] baud_reload_value;
   logic rstart_en, stop_en, bus_collision_flag, seq_done, sda_o, sda_oe, scl_o, scl_oe, sda, scl;
   int err_total, samples_checked, cycles, seed;
   // Scenario table: stop or repeated start, peer action, collision expected
   logic [10:0] t_stp = 11'h3C0;
   logic [10:0] t_col = 11'h18A;
   int t_mode[11] = '{0, 1, 0, 2, 0, 3, 0, 1, 2, 3, 0};

   rsc_seq dut (.sys_clk(sys_clk), .rst_b(rst_b), .baud_reload_value(baud_reload_value),
      .rstart_req(rstart_req), .stop_req(stop_req), .flag_clear(flag_clear), .rstart_en(rstart_en),
      .stop_en(stop_en), .bus_collision_flag(bus_collision_flag), .seq_done(seq_done), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe));
   rsc_bus_peer peer (.sda_oe(sda_oe), .scl_oe(scl_oe), .sda_pull(sda_pull), .scl_pull(scl_pull),
      .sda(sda), .scl(scl));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   // Hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 8000) begin
         err_total++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One condition with the peer acting once SCL is released after being held
   task automatic run_seq(input logic stp, input int mode, input logic exp_col);
      int n, cyc, stretch, hi, min_cyc;
      logic armed, done_seen, en_seen;
      n = $urandom_range(7, 4);
      armed = 1'b0;
      en_seen = 1'b0;
      done_seen = 1'b0;
      stretch = 0;
      hi = 0;
      cyc = 0;
      @(negedge sys_clk);
      baud_reload_value = 7'(n);
      flag_clear = 1'b1;
      rstart_req = !stp;
      stop_req = stp;
      @(negedge sys_clk);
      flag_clear = 1'b0;
      rstart_req = 1'b0;
      stop_req = 1'b0;
      while (done_seen !== 1'b1 && bus_collision_flag !== 1'b1 && cyc < 3000) begin
         @(negedge sys_clk);
         cyc++;
         done_seen = seq_done;
         if ((stp ? stop_en : rstart_en) === 1'b1) en_seen = 1'b1;
         if (scl_oe === 1'b1) armed = 1'b1;
         hi = (armed && scl_oe === 1'b0 && scl) ? hi + 1 : 0;
         if (armed && scl_oe === 1'b0) begin
            if (mode == 1) sda_pull = 1'b1;
            if (mode == 2 && hi == 3) scl_pull = 1'b1;
            if (mode == 3) scl_pull = (stretch < 20);
            if (mode == 3) stretch++;
         end
      end
      sda_pull = 1'b0;
      scl_pull = 1'b0;
      repeat (2) @(negedge sys_clk);
      // Shortest legal run: one count per phase, plus any stretch
      min_cyc = (stp ? 2 : 3) * n + (mode == 3 ? 20 : 0);
      check("collision_flag", exp_col, bus_collision_flag);
      check("done_pulse", !exp_col, done_seen);
      check("enables_clear", 1'b0, rstart_en | stop_en);
      check("enable_seen", 1'b1, en_seen);
      check("sda_pulled", !exp_col && !stp, sda_oe);
      check("scl_pulled", !exp_col && !stp, scl_oe);
      check("open_drain", 1'b0, sda_o | scl_o);
      if (!exp_col) check("count_length", 1'b1, logic'(cyc >= min_cyc));
   endtask

   initial begin
      rst_b = 1'b0;
      rstart_req = 1'b0;
      stop_req = 1'b0;
      flag_clear = 1'b0;
      sda_pull = 1'b0;
      scl_pull = 1'b0;
      baud_reload_value = 7'h04;
      err_total = 0;
      samples_checked = 0;
      cycles = 0;
      seed = $urandom(22);
      repeat (10) @(negedge sys_clk);
      rst_b = 1'b1;
      check("flag_reset", 1'b0, bus_collision_flag);
      for (int i = 0; i < 11; i++) begin
         run_seq(t_stp[i], t_mode[i], t_col[i]);
      end
      end_of_test();
   end
endmodule // testbench
